// File: logic/dialer_ctrl.sv
// dialer sequencer: tones, pulse trains, wait and break cycles, done flag and interrupt
`timescale 1ns/1ps
module dialer_ctrl
    import dialer_pkg::*;
#(
    parameter int TONE_MIN_CYCLES = TONE_MIN_CYC,
    parameter int PULSE_BREAK_CYCLES = PULSE_BREAK_CYC,
    parameter int PULSE_MAKE_CYCLES = PULSE_MAKE_CYC,
    parameter int SET_STEP_CYCLES = SET_STEP_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    output logic tone_on,
    output logic [DATA_W-1:0] tone_code,
    output logic pulse_open,
    output logic line_break,
    output logic dial_wait,
    output logic busy,
    output logic irq
);

    // ========================================
    // state
    typedef struct packed {
        seq_state_type state;
        logic [DATA_W-1:0] code;
        logic [DATA_W-1:0] pulses_left;
        logic [DATA_W-1:0] gap_set;
        logic [DATA_W-1:0] brk_set;
        logic [DATA_W-1:0] wait_set;
        logic tone_mode;
        logic tone_hold;
        logic min_done;
        logic irq_en;
        logic flag;
        logic irq;
        logic busy;
        logic [DATA_W-1:0] rdata;
    } ctrl_state_type;

    ctrl_state_type s_reg;
    ctrl_state_type s_next;

    timer_if tif ();

    duration_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .tif(tif)
    );

    // ========================================
    // helpers
    function automatic logic [CNT_W-1:0] steps_to_cycles(
        input logic [DATA_W-1:0] steps
    );
        longint prod;
        prod = longint'(steps) * longint'(SET_STEP_CYCLES);
        return prod[CNT_W-1:0];
    endfunction

    logic wr_code;
    logic wr_trig;
    logic wr_flag;
    logic idle_free;
    logic finish;
    logic [DATA_W-1:0] rd_mux;

    assign wr_code = wr && (addr == ADDR_CODE);
    assign wr_trig = wr && (addr == ADDR_TRIG);
    assign wr_flag = wr && (addr == ADDR_FLAG);
    // a new function only starts from idle with the done flag clear
    assign idle_free = s_reg.state[S_IDLE] && !s_reg.flag;

    // ========================================
    // read data, one cycle after the strobe
    always_comb
    begin
        rd_mux = '0;
        case (addr)
            ADDR_GAP: rd_mux = s_reg.gap_set;
            ADDR_BREAK_LEN: rd_mux = s_reg.brk_set;
            ADDR_WAIT_LEN: rd_mux = s_reg.wait_set;
            ADDR_MODE: rd_mux[MODE_TONE_BIT] = s_reg.tone_mode;
            ADDR_TRIG: rd_mux = '0;
            ADDR_TONE_HOLD: rd_mux[TONE_HOLD_BIT] = s_reg.tone_hold;
            ADDR_CODE: rd_mux = s_reg.code;
            ADDR_IRQ_EN: rd_mux[IRQ_EN_BIT] = s_reg.irq_en;
            ADDR_FLAG: rd_mux[FLAG_BIT] = s_reg.flag;
            default: rd_mux = '0;
        endcase
    end

    // ========================================
    // next state
    always_comb
    begin
        s_next = s_reg;
        finish = 1'b0;
        tif.load = 1'b0;
        tif.load_val = '0;
        s_next.rdata = rd ? rd_mux : '0;

        // plain control registers
        if (wr)
        begin
            case (addr)
                ADDR_GAP: s_next.gap_set = wdata;
                ADDR_BREAK_LEN: s_next.brk_set = wdata;
                ADDR_WAIT_LEN: s_next.wait_set = wdata;
                ADDR_MODE: s_next.tone_mode = wdata[MODE_TONE_BIT];
                ADDR_TONE_HOLD: s_next.tone_hold = wdata[TONE_HOLD_BIT];
                ADDR_CODE: s_next.code = wdata;
                ADDR_IRQ_EN: s_next.irq_en = wdata[IRQ_EN_BIT];
                default:
                begin
                end
            endcase
        end

        // sequencer
        case (s_reg.state)
            ST_IDLE:
            begin
                if (idle_free && wr_code)
                begin
                    tif.load = 1'b1;
                    if (s_reg.tone_mode)
                    begin
                        s_next.state = ST_TONE;
                        s_next.min_done = 1'b0;
                        tif.load_val = CNT_W'(TONE_MIN_CYCLES);
                    end
                    else
                    begin
                        // hold only applies to tones
                        s_next.state = ST_PBRK;
                        s_next.pulses_left = wdata;
                        tif.load_val = CNT_W'(PULSE_BREAK_CYCLES);
                    end
                end
                else if (idle_free && wr_trig && wdata[TRIG_BREAK_BIT])
                begin
                    s_next.state = ST_FLASH;
                    tif.load = 1'b1;
                    tif.load_val = steps_to_cycles(s_reg.brk_set);
                end
                else if (idle_free && wr_trig && wdata[TRIG_WAIT_BIT])
                begin
                    s_next.state = ST_WAIT;
                    tif.load = 1'b1;
                    tif.load_val = steps_to_cycles(s_reg.wait_set);
                end
            end
            ST_TONE:
            begin
                if (tif.expired)
                begin
                    s_next.min_done = 1'b1;
                end
                // never shorter than the minimum, held while hold is set
                if ((s_reg.min_done || tif.expired) && !s_next.tone_hold)
                begin
                    s_next.state = ST_IDLE;
                    finish = 1'b1;
                end
            end
            ST_PBRK:
            begin
                if (tif.expired)
                begin
                    s_next.state = ST_PMAKE;
                    s_next.pulses_left = s_reg.pulses_left - 1'b1;
                    tif.load = 1'b1;
                    tif.load_val = CNT_W'(PULSE_MAKE_CYCLES);
                end
            end
            ST_PMAKE:
            begin
                if (tif.expired)
                begin
                    tif.load = 1'b1;
                    if (s_reg.pulses_left == '0)
                    begin
                        s_next.state = ST_GAP;
                        tif.load_val = steps_to_cycles(s_reg.gap_set);
                    end
                    else
                    begin
                        s_next.state = ST_PBRK;
                        tif.load_val = CNT_W'(PULSE_BREAK_CYCLES);
                    end
                end
            end
            ST_GAP:
            begin
                if (tif.expired)
                begin
                    s_next.state = ST_IDLE;
                    finish = 1'b1;
                end
            end
            ST_WAIT:
            begin
                if (wr_trig && !wdata[TRIG_WAIT_BIT])
                begin
                    s_next.state = ST_IDLE;
                end
                else if (tif.expired)
                begin
                    s_next.state = ST_IDLE;
                    finish = 1'b1;
                end
            end
            ST_FLASH:
            begin
                if (wr_trig && !wdata[TRIG_BREAK_BIT])
                begin
                    s_next.state = ST_IDLE;
                end
                else if (tif.expired)
                begin
                    s_next.state = ST_IDLE;
                    finish = 1'b1;
                end
            end
            default:
            begin
                s_next.state = ST_IDLE;
            end
        endcase

        // done flag: a finishing cycle wins over a clear in the same cycle
        if (wr_flag && wdata[FLAG_BIT])
        begin
            s_next.flag = 1'b0;
        end
        if (finish)
        begin
            s_next.flag = 1'b1;
        end

        // request stands as long as flag and enable are both set
        s_next.irq = s_next.flag && s_next.irq_en;
        s_next.busy = !s_next.state[S_IDLE];
    end

    // ========================================
    // registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_reg.state <= ST_IDLE;
            s_reg.code <= CODE_RST;
            s_reg.pulses_left <= '0;
            s_reg.gap_set <= SET_RST;
            s_reg.brk_set <= SET_RST;
            s_reg.wait_set <= SET_RST;
            s_reg.tone_mode <= 1'b0;
            s_reg.tone_hold <= 1'b0;
            s_reg.min_done <= 1'b0;
            s_reg.irq_en <= 1'b0;
            s_reg.flag <= 1'b0;
            s_reg.irq <= 1'b0;
            s_reg.busy <= 1'b0;
            s_reg.rdata <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ========================================
    // outputs
    assign rdata = s_reg.rdata;
    assign tone_on = s_reg.state[S_TONE];
    assign tone_code = s_reg.code;
    assign pulse_open = s_reg.state[S_PBRK];
    assign line_break = s_reg.state[S_FLASH];
    assign dial_wait = s_reg.state[S_WAIT];
    assign busy = s_reg.busy;
    assign irq = s_reg.irq;

endmodule

// File: logic/dialer_pkg.sv
// constants, register map and state codes of the telephone dialer control block
package dialer_pkg;

    // ========================================
    // bus and counter widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;
    localparam int CNT_W = 26;

    // ========================================
    // timing
    localparam int CLK_KHZ = 25000;
    localparam int TONE_MIN_MS = 94;
    localparam int PULSE_BREAK_MS = 60;
    localparam int PULSE_MAKE_MS = 40;
    localparam int SET_STEP_MS = 100;
    localparam int TONE_MIN_CYC = TONE_MIN_MS * CLK_KHZ;
    localparam int PULSE_BREAK_CYC = PULSE_BREAK_MS * CLK_KHZ;
    localparam int PULSE_MAKE_CYC = PULSE_MAKE_MS * CLK_KHZ;
    localparam int SET_STEP_CYC = SET_STEP_MS * CLK_KHZ;

    // ========================================
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_GAP = 16'hff10;
    localparam logic [ADDR_W-1:0] ADDR_BREAK_LEN = 16'hff11;
    localparam logic [ADDR_W-1:0] ADDR_WAIT_LEN = 16'hff12;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 16'hff13;
    localparam logic [ADDR_W-1:0] ADDR_TRIG = 16'hff14;
    localparam logic [ADDR_W-1:0] ADDR_TONE_HOLD = 16'hff16;
    localparam logic [ADDR_W-1:0] ADDR_CODE = 16'hff17;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 16'hffe9;
    localparam logic [ADDR_W-1:0] ADDR_FLAG = 16'hfff9;

    // ========================================
    // field positions
    localparam int TRIG_WAIT_BIT = 1;
    localparam int TRIG_BREAK_BIT = 0;
    localparam int TONE_HOLD_BIT = 3;
    localparam int MODE_TONE_BIT = 0;
    localparam int IRQ_EN_BIT = 0;
    localparam int FLAG_BIT = 0;

    // ========================================
    // reset values
    localparam logic [DATA_W-1:0] CODE_RST = 4'h0;
    localparam logic [DATA_W-1:0] SET_RST = 4'h1;

    // ========================================
    // sequencer states, one-hot
    localparam int S_IDLE = 0;
    localparam int S_TONE = 1;
    localparam int S_PBRK = 2;
    localparam int S_PMAKE = 3;
    localparam int S_GAP = 4;
    localparam int S_WAIT = 5;
    localparam int S_FLASH = 6;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_TONE = 7'h02,
        ST_PBRK = 7'h04,
        ST_PMAKE = 7'h08,
        ST_GAP = 7'h10,
        ST_WAIT = 7'h20,
        ST_FLASH = 7'h40
    } seq_state_type;

endpackage

// File: logic/duration_timer.sv
// down counter that pulses expired during the last cycle of its loaded cycle count
`timescale 1ns/1ps
module duration_timer
    import dialer_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    timer_if.tmr tif
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic expired;
    } tmr_state_type;

    tmr_state_type s_reg;
    tmr_state_type s_next;

    always_comb
    begin
        s_next = s_reg;
        if (tif.load)
        begin
            s_next.cnt = tif.load_val;
        end
        else if (s_reg.cnt != '0)
        begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
        // flag the last counted cycle so the user leaves on the edge that ends the count
        s_next.expired = (s_next.cnt == CNT_W'(1));
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tif.expired = s_reg.expired;

endmodule

// File: logic/timer_if.sv
// load and expiry signals between the sequencer and its duration timer
`timescale 1ns/1ps
interface timer_if;
    import dialer_pkg::*;
    logic load;
    logic [CNT_W-1:0] load_val;
    logic expired;
    modport ctrl (output load, output load_val, input expired);
    modport tmr (input load, input load_val, output expired);
endinterface

// File: tb/dialer_sva.sv
// checker of the dialer control block, watching only the top module ports
`timescale 1ns/1ps
module dialer_sva
    import dialer_pkg::*;
#(
    parameter int TONE_MIN_CYCLES = 20
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic tone_on,
    input wire logic pulse_open,
    input wire logic dial_wait,
    input wire logic busy,
    input wire logic irq
);
    logic hold_m;
    logic en_m;
    logic held;
    int tone_len;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ========================================
    // mirrors of written controls and of the running tone length
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hold_m <= 1'b0;
            en_m <= 1'b0;
            held <= 1'b0;
            tone_len <= 0;
        end
        else
        begin
            if (wr && addr == ADDR_TONE_HOLD)
                hold_m <= wdata[TONE_HOLD_BIT];
            if (wr && addr == ADDR_IRQ_EN)
                en_m <= wdata[IRQ_EN_BIT];
            held <= tone_on && (held || hold_m);
            tone_len <= tone_on ? tone_len + 1 : 0;
        end
    end

    // ========================================
    // assertions
    a_tone_exact: assert property ($fell(tone_on) && !held |-> tone_len == TONE_MIN_CYCLES)
        else $error("tone without hold has the wrong length");
    a_tone_min: assert property ($fell(tone_on) |-> tone_len >= TONE_MIN_CYCLES)
        else $error("tone shorter than the minimum");
    a_tone_held: assert property (tone_on && hold_m
        && !(wr && addr == ADDR_TONE_HOLD && !wdata[TONE_HOLD_BIT]) |=> tone_on)
        else $error("tone stopped while hold is set");
    a_hold_readback: assert property ($past(rd) && $past(addr) == ADDR_TONE_HOLD
        |-> rdata[TONE_HOLD_BIT] == hold_m)
        else $error("tone hold reads back wrong");
    a_irq_masked: assert property (!en_m && !$past(en_m) |-> !irq)
        else $error("interrupt raised while disabled");
    a_irq_after_tone: assert property ($fell(tone_on) && en_m |=> irq)
        else $error("no interrupt after tone end");
    a_irq_cleared: assert property (wr && addr == ADDR_FLAG && wdata[FLAG_BIT] && !busy
        |=> ##1 !irq)
        else $error("interrupt stays after flag clear");
    a_wait_cancel: assert property (wr && addr == ADDR_TRIG && !wdata[TRIG_WAIT_BIT]
        && dial_wait |=> !dial_wait)
        else $error("wait cycle not cancelled");
    a_trig_zero: assert property ($past(rd) && $past(addr) == ADDR_TRIG |-> rdata == 4'h0)
        else $error("trigger location reads nonzero");

    c_tone_held: cover property ($fell(tone_on) && held);
    c_pulse: cover property ($rose(pulse_open));
    c_cancel: cover property (wr && addr == ADDR_TRIG && dial_wait);
endmodule

bind dialer_ctrl dialer_sva #(.TONE_MIN_CYCLES(TONE_MIN_CYCLES)) dialer_sva_i (.core_clk, .rst,
    .addr, .wdata, .wr, .rd, .rdata, .tone_on, .pulse_open, .dial_wait, .busy, .irq);

// File: tb/line_model.sv
// telephone line side: measures tone, break and wait lengths and counts dial pulses
`timescale 1ns/1ps
module line_model
(
    input wire logic core_clk,
    input wire logic tone_on,
    input wire logic pulse_open,
    input wire logic line_break,
    input wire logic dial_wait,
    output int tone_len,
    output int pulse_cnt,
    output int break_len,
    output int wait_len
);
    logic [3:0] prev = 4'h0;

    function automatic int grow(input logic now, input logic was, input int len);
        return now ? (was ? len + 1 : 1) : len;
    endfunction

    always @(posedge core_clk)
    begin
        tone_len <= grow(tone_on, prev[0], tone_len);
        if (pulse_open && !prev[1])
            pulse_cnt <= pulse_cnt + 1;
        break_len <= grow(line_break, prev[2], break_len);
        wait_len <= grow(dial_wait, prev[3], wait_len);
        prev <= {dial_wait, line_break, pulse_open, tone_on};
    end
endmodule

// File: tb/tb.sv
// self-checking testbench of the dialer control block
`timescale 1ns/1ps
module tb;
    import dialer_pkg::*;
    localparam int TMIN = 20;
    localparam int STEP = 10;
    logic core_clk, rst, wr, rd, tone_on, pulse_open, line_break, dial_wait, busy, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, tone_code, rv;
    logic [ADDR_W-1:0] rst_addr [7] = '{ADDR_TRIG, ADDR_TONE_HOLD, ADDR_IRQ_EN, ADDR_FLAG,
        ADDR_MODE, ADDR_CODE, 16'hff00};
    int tone_len, pulse_cnt, break_len, wait_len;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int n, p0, steps, flag_m, en_m;

    dialer_ctrl #(.TONE_MIN_CYCLES(TMIN), .PULSE_BREAK_CYCLES(6), .PULSE_MAKE_CYCLES(4),
        .SET_STEP_CYCLES(STEP)) dialer_ctrl_i (.core_clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .tone_on, .tone_code, .pulse_open, .line_break, .dial_wait, .busy, .irq);
    line_model line_model_i (.core_clk, .tone_on, .pulse_open, .line_break, .dial_wait,
        .tone_len, .pulse_cnt, .break_len, .wait_len);

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ========================================
    // bus, check and closing tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [15:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic idle_wait();
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            #1 k++;
        end
        while (busy === 1'b1 && k < 2000);
        chk("busy", busy, 0);
        flag_m = 1;
        @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ========================================
    // main sequence
    initial
    begin
        {rst, wr, rd, addr, wdata, flag_m, en_m} = '0;
        rst = 1'b1;
        void'($urandom(32'he807));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (rst_addr[i])
        begin
            rd_reg(rst_addr[i]);
            chk("reset read", rv, 0);
        end
        wr_reg(ADDR_IRQ_EN, 4'h1);
        en_m = 1;
        wr_reg(ADDR_MODE, 4'h1);
        n = $urandom_range(15, 1);
        wr_reg(ADDR_CODE, n[3:0]);
        chk("tone_code", tone_code, n);
        chk("tone_on", tone_on, 1);
        idle_wait();
        chk("tone length", tone_len, TMIN);
        chk("irq", irq, flag_m & en_m);
        wr_reg(ADDR_CODE, n[3:0]);
        chk("busy while flagged", busy, 0);
        wr_reg(ADDR_FLAG, 4'h0);
        rd_reg(ADDR_FLAG);
        chk("flag after 0", rv[0], 1);
        wr_reg(ADDR_FLAG, 4'h1);
        flag_m = 0;
        rd_reg(ADDR_FLAG);
        chk("flag after 1", rv[0], flag_m);
        chk("irq after clear", irq, 0);
        for (int h = 0; h < 2; h++)
        begin
            wr_reg(ADDR_TONE_HOLD, 4'h8);
            rd_reg(ADDR_TONE_HOLD);
            chk("hold readback", rv, 8);
            wr_reg(ADDR_CODE, n[3:0]);
            repeat (h ? 3 : 40) @(posedge core_clk);
            #1 chk("tone held", tone_on, 1);
            wr_reg(ADDR_TONE_HOLD, 4'h0);
            idle_wait();
            // long hold: the clear lands 42 cycles after the tone started
            chk("held tone length", tone_len, h ? TMIN : 42);
            wr_reg(ADDR_FLAG, 4'h1);
        end
        wr_reg(ADDR_IRQ_EN, 4'h0);
        en_m = 0;
        wr_reg(ADDR_MODE, 4'h0);
        wr_reg(ADDR_TONE_HOLD, 4'h8);
        p0 = pulse_cnt;
        n = $urandom_range(4, 1);
        wr_reg(ADDR_CODE, n[3:0]);
        idle_wait();
        chk("pulses", pulse_cnt - p0, n);
        chk("masked irq", irq, flag_m & en_m);
        wr_reg(ADDR_IRQ_EN, 4'h1);
        en_m = 1;
        rd_reg(ADDR_IRQ_EN);
        chk("enable readback", rv, 1);
        chk("irq on enable", irq, flag_m & en_m);
        wr_reg(ADDR_FLAG, 4'h1);
        wr_reg(ADDR_TONE_HOLD, 4'h0);
        for (int b = 0; b < 2; b++)
        begin
            steps = $urandom_range(3, 1);
            wr_reg(b ? ADDR_BREAK_LEN : ADDR_WAIT_LEN, steps[3:0]);
            wr_reg(ADDR_TRIG, b ? 4'h1 : 4'h2);
            idle_wait();
            chk("cycle length", b ? break_len : wait_len, steps * STEP);
            chk("irq after cycle", irq, flag_m & en_m);
            wr_reg(ADDR_FLAG, 4'h1);
            wr_reg(ADDR_TRIG, b ? 4'h1 : 4'h2);
            repeat (5) @(posedge core_clk);
            wr_reg(ADDR_TRIG, 4'h0);
            chk("cancelled", {dial_wait, line_break, busy}, 0);
            rd_reg(ADDR_FLAG);
            chk("no flag on cancel", rv, 0);
        end
        tally_and_finish();
    end
endmodule
